// [hdl/cue_seq_pkg.sv]
// Package for the projector dissolve cue sequencer.
// Assumes a single 40 MHz clock; times are kept in tenths of a second here, except ADVANCE_TIME_S, which is in seconds.
package cue_seq_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int NUM_SCREENS = 5;
  localparam int CLK_HZ = 40_000_000;
  localparam int TENTHS_PER_SEC = 10;
  localparam int CYC_PER_TENTH = CLK_HZ / TENTHS_PER_SEC;
  localparam int ADVANCE_TIME_S = 1;
  localparam int ADVANCE_TENTHS = ADVANCE_TIME_S * TENTHS_PER_SEC;
  localparam int HARD_CUT_TENTHS = 1;
  localparam int CUT_TENTHS = 2;
  localparam int SEC1_TENTHS = 10;
  localparam int SEC2_TENTHS = 20;
  localparam int SEC4_TENTHS = 40;
  localparam int SEC8_TENTHS = 80;
  localparam int SEC16_TENTHS = 160;
  localparam int SEC32_TENTHS = 320;
  localparam int TENTH_W = 9;
  localparam int PRESC_W = 22;
  localparam logic [13:0] CUE_FIRST = 14'h0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPD_NONE, SPD_CUT, SPD_HARD, SPD_1S, SPD_2S, SPD_4S, SPD_8S, SPD_16S
  } speed_unused_t;

  typedef struct packed {
    logic eight_second_dissolve;
    logic four_second_dissolve;
    logic two_second_dissolve;
    logic cut;
    logic shift;
    logic alternate_no_advance;
    logic tray_step_forward;
    logic tray_step_backward;
    logic aux;
    logic [2:0] pos;
    logic [NUM_SCREENS-1:0] screens;
  } key_cmd_t;

  typedef enum logic [2:0] {
    ST_READY, ST_FADE, ST_ADVANCE, ST_STEP
  } scr_state_t;

endpackage : cue_seq_pkg

// [hdl/screen_unit.sv]
// One screen: three lamps, tray drives and status lights.
// Assumes the tenth-second tick comes from the same clock domain.
`timescale 1ns/1ps
module screen_unit
  import cue_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic home_i,
  // Command
  input wire logic go_i,
  input wire logic [2:0] on_mask_i,
  input wire logic [2:0] off_mask_i,
  input wire logic [2:0] adv_mask_i,
  input wire logic adv_back_i,
  input wire logic [TENTH_W-1:0] fade_i,
  // Status
  output logic [2:0] lamp_o,
  output logic [2:0] adv_o,
  output logic [2:0] back_o,
  output logic ready_o,
  output logic fading_o
);

  typedef struct packed {
    scr_state_t st;
    logic [2:0] lamp;
    logic [2:0] adv;
    logic [2:0] pend;
    logic back;
    logic [TENTH_W-1:0] cnt;
  } scr_t;

  scr_t s_ff;
  scr_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (home_i) begin
      nxt_s.lamp = 3'h0;
      nxt_s.adv = 3'h0;
      nxt_s.st = ST_READY;
    end else begin
      case (s_ff.st)
        ST_READY, ST_ADVANCE, ST_FADE: begin
          if (go_i) begin
            nxt_s.lamp = (s_ff.lamp | on_mask_i) & ~off_mask_i;
            nxt_s.pend = adv_mask_i;
            nxt_s.back = adv_back_i;
            nxt_s.cnt = fade_i;
            nxt_s.adv = 3'h0;
            nxt_s.st = ST_FADE;
            if (on_mask_i == 3'h0 && off_mask_i == 3'h0) begin
              // Pure tray step: drive at once
              nxt_s.adv = adv_mask_i;
              nxt_s.cnt = TENTH_W'(ADVANCE_TENTHS);
              nxt_s.st = ST_ADVANCE;
            end else if (fade_i == '0) begin
              // Alternate cut: no fade, no advance
              nxt_s.pend = 3'h0;
              nxt_s.st = ST_READY;
            end
          end else if (tick_i && s_ff.st != ST_READY) begin
            if (s_ff.cnt > 9'h001) begin
              nxt_s.cnt = s_ff.cnt - 9'h001;
            end else if (s_ff.st == ST_FADE && s_ff.pend != 3'h0) begin
              nxt_s.adv = s_ff.pend;
              nxt_s.cnt = TENTH_W'(ADVANCE_TENTHS);
              nxt_s.st = ST_ADVANCE;
            end else begin
              nxt_s.adv = 3'h0;
              nxt_s.pend = 3'h0;
              nxt_s.st = ST_READY;
            end
          end
        end
        default: nxt_s.st = ST_READY;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lamp_o = s_ff.lamp;
  assign adv_o = s_ff.adv;
  assign back_o = {3{s_ff.back}} & s_ff.adv;
  assign ready_o = (s_ff.st == ST_READY);
  assign fading_o = (s_ff.st == ST_FADE);

endmodule : screen_unit

// [hdl/cue_sequencer.sv]
// Cue interpreter and program store for a five-screen projector controller.
// Assumes keys and cue inputs are asynchronous pins; lamp outputs feed power packs.
// How it works
// - Shift remaps speeds: 32s, 16s, 1s, hard cut
// - Unnamed transition moves lit lamp left-center-right
// - Reset starts dark; first cue lights left
// - Position keys switch only named projectors
// - Position plus screens without speed presets only
// - Positions with step move only named trays
// - Left/right keys pick auxiliary bank
// - Alternate cut: no advance, ready stays
// - Alternate dissolve: no advance, ready after fade
// - Normal transitions advance outgoing, then ready
// - Hard cut readies sooner than cut
// - Unnamed projectors keep their lamp state
// - Replay cue runs next step, counter plus one
// - Three-projector: accept cue once outgoing off
// - Red left/right, yellow center, green ready
// - Cue counter starts 0001, shows next cue
// - One second allowed for tray advance
`timescale 1ns/1ps
module cue_sequencer
  import cue_seq_pkg::*;
#(
  parameter int PROG_DEPTH = 64
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Keyboard and remote, asynchronous pins
  input wire logic key_strobe_i,
  input wire key_cmd_t key_i,
  input wire logic cue_i,
  input wire logic reset_key_i,
  input wire logic clear_key_i,
  input wire logic replay_i,
  input wire logic three_proj_i,
  // Projector power packs
  output logic [3*NUM_SCREENS-1:0] lamp_o,
  output logic [3*NUM_SCREENS-1:0] tray_fwd_o,
  output logic [3*NUM_SCREENS-1:0] tray_back_o,
  output logic [NUM_SCREENS-1:0] aux_left_o,
  output logic [NUM_SCREENS-1:0] aux_right_o,
  // Indicators
  output logic [NUM_SCREENS-1:0] red_o,
  output logic [NUM_SCREENS-1:0] yellow_o,
  output logic [NUM_SCREENS-1:0] green_o,
  output logic [13:0] cue_count_o
);

  localparam int AW = $clog2(PROG_DEPTH);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = $bits(key_cmd_t) + 6;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {key_strobe_i, key_i, cue_i, reset_key_i, clear_key_i,
                   replay_i, three_proj_i};
      sync2_ff <= sync1_ff;
    end
  end
  logic s_strobe;
  key_cmd_t s_key;
  logic s_cue, s_reset, s_clear, s_replay, s_three;
  assign {s_strobe, s_key, s_cue, s_reset, s_clear, s_replay, s_three} = sync2_ff;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [TENTH_W-1:0] fade_of(input key_cmd_t k);
    logic [TENTH_W-1:0] t;
    t = TENTH_W'(CUT_TENTHS);
    if (k.eight_second_dissolve) begin
      t = TENTH_W'(k.shift ? SEC32_TENTHS : SEC8_TENTHS);
    end else if (k.four_second_dissolve) begin
      t = TENTH_W'(k.shift ? SEC16_TENTHS : SEC4_TENTHS);
    end else if (k.two_second_dissolve) begin
      t = TENTH_W'(k.shift ? SEC1_TENTHS : SEC2_TENTHS);
    end else if (k.alternate_no_advance) begin
      t = '0;
    end else if (k.shift) begin
      t = TENTH_W'(HARD_CUT_TENTHS);
    end
    return t;
  endfunction : fade_of

  function automatic logic has_speed(input key_cmd_t k);
    return k.eight_second_dissolve | k.four_second_dissolve | k.two_second_dissolve
           | k.cut | k.alternate_no_advance;
  endfunction : has_speed

  function automatic logic [2:0] next_pos(input logic [2:0] lit);
    logic [2:0] n;
    case (lit)
      3'h1: n = 3'h2;
      3'h2: n = 3'h4;
      3'h4: n = 3'h1;
      default: n = 3'h1;
    endcase
    return n;
  endfunction : next_pos

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  typedef struct packed {
    key_cmd_t pend;
    logic pend_v;
    logic strobe_d;
    logic cue_d;
    logic [NUM_SCREENS-1:0][2:0] preset;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [13:0] count;
    logic [PRESC_W-1:0] presc;
    logic tick;
    logic home;
    logic [NUM_SCREENS-1:0] aux_l;
    logic [NUM_SCREENS-1:0] aux_r;
  } ctl_t;

  ctl_t c_ff;
  ctl_t nxt_c;
  key_cmd_t prog_ff [PROG_DEPTH];

  logic [NUM_SCREENS-1:0] ready;
  logic [NUM_SCREENS-1:0] fading;
  logic [NUM_SCREENS-1:0][2:0] lamp;
  logic [NUM_SCREENS-1:0][2:0] adv;
  logic [NUM_SCREENS-1:0][2:0] back;
  logic [NUM_SCREENS-1:0] go;
  logic [NUM_SCREENS-1:0][2:0] on_m;
  logic [NUM_SCREENS-1:0][2:0] off_m;
  logic [NUM_SCREENS-1:0][2:0] adv_m;
  logic step_back;
  key_cmd_t exec;
  logic exec_v;
  logic store;

  always_comb begin
    nxt_c = c_ff;
    nxt_c.strobe_d = s_strobe;
    nxt_c.cue_d = s_cue;
    nxt_c.home = 1'b0;
    nxt_c.aux_l = '0;
    nxt_c.aux_r = '0;
    store = 1'b0;
    exec_v = 1'b0;
    exec = c_ff.pend;
    if (c_ff.presc == PRESC_W'(CYC_PER_TENTH - 1)) begin
      nxt_c.presc = '0;
      nxt_c.tick = 1'b1;
    end else begin
      nxt_c.presc = c_ff.presc + 1'b1;
      nxt_c.tick = 1'b0;
    end
    if (s_reset) begin
      nxt_c.home = 1'b1;
      nxt_c.rd_ptr = '0;
      nxt_c.count = CUE_FIRST;
      nxt_c.preset = '0;
      nxt_c.pend_v = 1'b0;
      if (s_clear) begin
        nxt_c.wr_ptr = '0;
      end
    end else if (s_clear) begin
      nxt_c.pend_v = 1'b0;
    end else if (s_cue && !c_ff.cue_d) begin
      if (s_replay) begin
        if (c_ff.rd_ptr != c_ff.wr_ptr) begin
          exec = prog_ff[c_ff.rd_ptr];
          exec_v = 1'b1;
          nxt_c.rd_ptr = c_ff.rd_ptr + 1'b1;
          nxt_c.count = c_ff.count + 14'h0001;
        end
      end else if (c_ff.pend_v) begin
        exec_v = 1'b1;
        store = (c_ff.wr_ptr != AW'(PROG_DEPTH - 1));
        nxt_c.pend_v = 1'b0;
        if (store) begin
          nxt_c.wr_ptr = c_ff.wr_ptr + 1'b1;
          nxt_c.rd_ptr = c_ff.wr_ptr + 1'b1;
          nxt_c.count = c_ff.count + 14'h0001;
        end
      end
    end
    // New key wins over a clear in the same cycle
    if (s_strobe && !c_ff.strobe_d) begin
      nxt_c.pend = s_key;
      nxt_c.pend_v = 1'b1;
    end
    // Per-screen command expansion
    step_back = exec.tray_step_backward;
    for (int i = 0; i < NUM_SCREENS; i++) begin
      go[i] = 1'b0;
      on_m[i] = 3'h0;
      off_m[i] = 3'h0;
      adv_m[i] = 3'h0;
      if (exec_v && exec.screens[i]) begin
        if (exec.aux) begin
          nxt_c.aux_l[i] = exec.pos[0];
          nxt_c.aux_r[i] = exec.pos[2];
        end else if (exec.tray_step_forward || exec.tray_step_backward) begin
          go[i] = 1'b1;
          adv_m[i] = (exec.pos != 3'h0) ? exec.pos : 3'h7;
        end else if (!has_speed(exec)) begin
          nxt_c.preset[i] = exec.pos;
        end else if (ready[i] || (s_three && !fading[i])) begin
          go[i] = 1'b1;
          nxt_c.preset[i] = 3'h0;
          if (exec.pos != 3'h0 || c_ff.preset[i] != 3'h0) begin
            on_m[i] = (exec.pos | c_ff.preset[i]) & ~lamp[i];
            off_m[i] = (exec.pos | c_ff.preset[i]) & lamp[i];
          end else begin
            on_m[i] = next_pos(lamp[i]);
            off_m[i] = lamp[i];
          end
          if (!exec.alternate_no_advance) begin
            adv_m[i] = off_m[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_ff <= '0;
      c_ff.count <= CUE_FIRST;
    end else begin
      c_ff <= nxt_c;
    end
  end

  always_ff @(posedge clk_i) begin
    if (store) begin
      prog_ff[c_ff.wr_ptr] <= c_ff.pend;
    end
  end

  // ----------------------------------------------------------------
  // Screens
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_SCREENS; g++) begin : g_scr
    screen_unit u_scr (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(c_ff.tick),
      .home_i(c_ff.home),
      .go_i(go[g]),
      .on_mask_i(on_m[g]),
      .off_mask_i(off_m[g]),
      .adv_mask_i(adv_m[g]),
      .adv_back_i(step_back),
      .fade_i(fade_of(exec)),
      .lamp_o(lamp[g]),
      .adv_o(adv[g]),
      .back_o(back[g]),
      .ready_o(ready[g]),
      .fading_o(fading[g])
    );
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lamp_o <= '0;
      tray_fwd_o <= '0;
      tray_back_o <= '0;
      red_o <= '0;
      yellow_o <= '0;
      green_o <= '0;
      aux_left_o <= '0;
      aux_right_o <= '0;
      cue_count_o <= CUE_FIRST;
    end else begin
      for (int i = 0; i < NUM_SCREENS; i++) begin
        lamp_o[3*i +: 3] <= lamp[i];
        tray_fwd_o[3*i +: 3] <= adv[i] & ~back[i];
        tray_back_o[3*i +: 3] <= back[i];
        red_o[i] <= lamp[i][0] | lamp[i][2];
        yellow_o[i] <= lamp[i][1];
        green_o[i] <= ready[i];
      end
      aux_left_o <= c_ff.aux_l;
      aux_right_o <= c_ff.aux_r;
      cue_count_o <= c_ff.count;
    end
  end

endmodule : cue_sequencer

// [sim/power_pack_model.sv]
// Power pack stand-in: records which trays were stepped forward and which aux banks fired.
// Assumes the sequencer's outputs are registered on the same clock.
`timescale 1ns/1ps
module power_pack_model
  import cue_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Drives from the sequencer
  input wire logic [3*NUM_SCREENS-1:0] fwd_i,
  input wire logic [NUM_SCREENS-1:0] aux_left_i,
  input wire logic [NUM_SCREENS-1:0] aux_right_i,
  // Observations
  output logic [3*NUM_SCREENS-1:0] stepped_o,
  output logic [NUM_SCREENS-1:0] aux_left_seen_o,
  output logic [NUM_SCREENS-1:0] aux_right_seen_o
);
  logic [3*NUM_SCREENS-1:0] fwd_d;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwd_d <= '0;
      stepped_o <= '0;
      aux_left_seen_o <= '0;
      aux_right_seen_o <= '0;
    end else begin
      fwd_d <= fwd_i;
      stepped_o <= stepped_o | (fwd_i & ~fwd_d);
      aux_left_seen_o <= aux_left_seen_o | aux_left_i;
      aux_right_seen_o <= aux_right_seen_o | aux_right_i;
    end
  end
endmodule : power_pack_model

// [sim/cue_seq_chk.sv]
// Checker for the cue sequencer pins.
// Assumes the tray drive and lamp outputs are registered on clk_i.
`timescale 1ns/1ps
module cue_seq_chk
  import cue_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched pins
  input wire logic cue_i,
  input wire logic reset_key_i,
  input wire logic [3*NUM_SCREENS-1:0] lamp_o,
  input wire logic [3*NUM_SCREENS-1:0] tray_fwd_o,
  input wire logic [3*NUM_SCREENS-1:0] tray_back_o,
  input wire logic [NUM_SCREENS-1:0] aux_left_o,
  input wire logic [NUM_SCREENS-1:0] red_o,
  input wire logic [NUM_SCREENS-1:0] yellow_o,
  input wire logic [NUM_SCREENS-1:0] green_o,
  input wire logic [13:0] cue_count_o
);
  logic cue_d_ff;
  logic [7:0] since_cue_ff;
  logic [NUM_SCREENS-1:0] lr_on;
  logic [NUM_SCREENS-1:0] ctr_on;
  logic [NUM_SCREENS-1:0] moving;

  always_comb begin
    for (int s = 0; s < NUM_SCREENS; s++) begin
      lr_on[s] = lamp_o[3*s] | lamp_o[3*s+2];
      ctr_on[s] = lamp_o[3*s+1];
      moving[s] = |(tray_fwd_o[3*s+:3] | tray_back_o[3*s+:3]);
    end
  end

  // Cycles since the cue pin last rose
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cue_d_ff <= 1'b0;
      since_cue_ff <= 8'hFF;
    end else begin
      cue_d_ff <= cue_i;
      if (cue_i && !cue_d_ff) begin
        since_cue_ff <= 8'h00;
      end else if (since_cue_ff != 8'hFF) begin
        since_cue_ff <= since_cue_ff + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reset_dark: assert property ($rose(rst_n_i) |-> lamp_o == '0 && cue_count_o == CUE_FIRST)
    else $error("lamps or counter wrong after reset");
  a_red_left_right: assert property (red_o == lr_on)
    else $error("red light does not match side lamps");
  a_yellow_center: assert property (yellow_o == ctr_on)
    else $error("yellow light does not match center lamp");
  a_green_not_moving: assert property ((moving & green_o) == '0)
    else $error("ready light on while a tray moves");
  a_count_plus_one: assert property ($changed(cue_count_o) && cue_count_o != CUE_FIRST
    |-> cue_count_o == $past(cue_count_o) + 14'h0001)
    else $error("cue counter did not step by one");
  a_count_after_cue: assert property ($changed(cue_count_o) && !reset_key_i
    |-> since_cue_ff <= 8'd12)
    else $error("cue counter moved without a cue");
  a_lamp_after_cue: assert property ($changed(lamp_o) && !reset_key_i
    |-> since_cue_ff <= 8'd12)
    else $error("lamp changed without a cue");
  a_aux_one_pulse: assert property (|aux_left_o |=> aux_left_o == '0)
    else $error("aux pulse longer than one cycle");
  a_tray_hold: assert property ($rose(|tray_fwd_o) |=> (|tray_fwd_o) [*8])
    else $error("tray drive dropped early");

  cover property ($changed(lamp_o));
  cover property (|aux_left_o);
  cover property ($rose(|tray_fwd_o));
endmodule : cue_seq_chk

bind cue_sequencer cue_seq_chk cue_seq_chk_inst (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .cue_i(cue_i),
  .reset_key_i(reset_key_i),
  .lamp_o(lamp_o),
  .tray_fwd_o(tray_fwd_o),
  .tray_back_o(tray_back_o),
  .aux_left_o(aux_left_o),
  .red_o(red_o),
  .yellow_o(yellow_o),
  .green_o(green_o),
  .cue_count_o(cue_count_o)
);

// [sim/tb_cue_sequencer.sv]
// Testbench for the cue sequencer with a model of lit positions per screen.
// Assumes lamp state shows at once; fades and tray advances outlast the run.
`timescale 1ns/1ps
module tb_cue_sequencer
  import cue_seq_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic key_strobe_i = 1'b0;
  logic cue_i = 1'b0;
  key_cmd_t key_i = '0;
  key_cmd_t k;
  logic [3*NUM_SCREENS-1:0] lamp_o, tray_fwd_o, tray_back_o, stepped;
  logic [3*NUM_SCREENS-1:0] exp_fwd = '0;
  logic [3*NUM_SCREENS-1:0] exp_back = '0;
  logic reset_key_i = 1'b0;
  logic clear_key_i = 1'b0;
  logic replay_i = 1'b0;
  logic three_proj_i = 1'b0;
  logic [NUM_SCREENS-1:0] aux_left_o, aux_right_o, red_o, yellow_o, green_o, aux_l, aux_r;
  logic [NUM_SCREENS-1:0] exp_green = 5'h1F;
  logic [13:0] cue_count_o;
  logic [15:0] lfsr = 16'h1713;
  logic [2:0] p;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int count = 1;
  int lit[NUM_SCREENS] = '{default: -1};

  always #12.5 clk_i = ~clk_i;

  cue_sequencer #(.PROG_DEPTH(64)) cue_sequencer_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .key_strobe_i(key_strobe_i), .key_i(key_i),
    .cue_i(cue_i), .reset_key_i(reset_key_i), .clear_key_i(clear_key_i),
    .replay_i(replay_i), .three_proj_i(three_proj_i), .lamp_o(lamp_o), .tray_fwd_o(tray_fwd_o),
    .tray_back_o(tray_back_o), .aux_left_o(aux_left_o), .aux_right_o(aux_right_o),
    .red_o(red_o), .yellow_o(yellow_o), .green_o(green_o), .cue_count_o(cue_count_o));

  power_pack_model power_pack_model_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fwd_i(tray_fwd_o), .aux_left_i(aux_left_o),
    .aux_right_i(aux_right_o), .stepped_o(stepped), .aux_left_seen_o(aux_l),
    .aux_right_seen_o(aux_r));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input key_cmd_t c, input logic fire);
    @(posedge clk_i);
    key_i <= c;
    key_strobe_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    key_strobe_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    cue_i <= fire;
    repeat (4) @(posedge clk_i);
    cue_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    if (fire) count++;
  endtask : send

  task automatic compare_all(input string name);
    logic [3*NUM_SCREENS-1:0] l;
    logic [NUM_SCREENS-1:0] r;
    logic [NUM_SCREENS-1:0] y;
    @(negedge clk_i);
    l = '0;
    for (int s = 0; s < NUM_SCREENS; s++) begin
      if (lit[s] >= 0) l[3*s+lit[s]] = 1'b1;
      r[s] = (lit[s] == 0) || (lit[s] == 2);
      y[s] = (lit[s] == 1);
    end
    check(16'(lamp_o), 16'(l));
    check(16'(red_o), 16'(r));
    check(16'(yellow_o), 16'(y));
    check(16'(green_o), 16'(exp_green));
    check(16'(cue_count_o), 16'(count));
    check(16'(tray_fwd_o), 16'(exp_fwd));
    check(16'(tray_back_o), 16'(exp_back));
    $display("test %s done", name);
  endtask : compare_all

  task automatic step(input string name);
    send(k, 1'b1);
    compare_all(name);
  endtask : step

  task automatic home_keys(input logic erase, input string name);
    @(posedge clk_i);
    reset_key_i <= 1'b1;
    clear_key_i <= erase;
    repeat (10) @(posedge clk_i);
    reset_key_i <= 1'b0;
    clear_key_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    lit = '{default: -1};
    exp_green = 5'h1F;
    exp_fwd = '0;
    exp_back = '0;
    count = 1;
    compare_all(name);
  endtask : home_keys

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    if (green_o !== 5'h1F) repeat (20) @(posedge clk_i);
    compare_all("reset");
    k = '0;
    k.eight_second_dissolve = 1'b1;
    k.screens = 5'h01;
    send(k, 1'b0);
    compare_all("pending only");
    lit[0] = 0;
    exp_green[0] = 1'b0;
    step("first cue");
    k = '0;
    k.alternate_no_advance = 1'b1;
    k.screens = 5'h02;
    lit[1] = 0;
    step("alternate cut");
    k = '0;
    k.two_second_dissolve = 1'b1;
    k.pos = 3'h4;
    k.screens = 5'h04;
    lit[2] = 2;
    exp_green[2] = 1'b0;
    step("named right");
    k = '0;
    k.pos = 3'h2;
    k.screens = 5'h08;
    step("preset center");
    k = '0;
    k.four_second_dissolve = 1'b1;
    k.screens = 5'h08;
    lit[3] = 1;
    exp_green[3] = 1'b0;
    step("preset used");
    lfsr = lfsr_next(lfsr);
    p = 3'(lfsr % 16'h0007) + 3'h1;
    k = '0;
    k.tray_step_forward = 1'b1;
    k.pos = p;
    k.screens = 5'h10;
    exp_fwd[14:12] = p;
    exp_green[4] = 1'b0;
    step("tray step");
    check(16'(stepped), 16'(exp_fwd));
    k = '0;
    k.aux = 1'b1;
    k.pos = 3'h1;
    k.screens = 5'h10;
    step("aux left");
    check(16'(aux_l), 16'h0010);
    check(16'(aux_r), 16'h0000);
    k = '0;
    k.tray_step_backward = 1'b1;
    k.screens = 5'h04;
    exp_back[8:6] = 3'h7;
    step("tray back");
    @(posedge clk_i);
    three_proj_i <= 1'b1;
    k = '0;
    k.two_second_dissolve = 1'b1;
    k.screens = 5'h10;
    lit[4] = 0;
    exp_fwd[14:12] = 3'h0;
    step("three projector");
    k = '0;
    k.cut = 1'b1;
    k.screens = 5'h01;
    step("busy screen");
    k = '0;
    k.shift = 1'b1;
    k.two_second_dissolve = 1'b1;
    k.screens = 5'h02;
    lit[1] = 1;
    exp_green[1] = 1'b0;
    step("shifted dissolve");
    home_keys(1'b0, "reset key");
    @(posedge clk_i);
    replay_i <= 1'b1;
    lit[0] = 0;
    exp_green[0] = 1'b0;
    step("replay first");
    lit[1] = 0;
    step("replay second");
    home_keys(1'b1, "erase");
    send(k, 1'b1);
    // Nothing stored, so the cue is ignored
    count = 1;
    compare_all("empty replay");
    conclude();
  end
endmodule : tb_cue_sequencer
